// ### src/boot_seq_pkg.sv
// package: constants and carriers of the cold reset and boot configuration sequencer
package boot_seq_pkg;
   localparam int          CFG_W          = 16;
   localparam int          BUS_W          = 32;
   localparam logic [15:0] CFG_RST        = 16'h0000;
   // boot vector field positions
   localparam int          CFG_PLL_LSB    = 0;
   localparam int          CFG_PLL_W      = 3;
   localparam int          CFG_TRACE_BIT  = 3;
   localparam int          CFG_HOLD_BIT   = 4;
   // pipeline clock codes, in MHz
   localparam logic [7:0]  PIPE_MHZ_MIN   = 8'h64;
   localparam logic [7:0]  PIPE_MHZ_MAX   = 8'h85;
   localparam int          GPIO_TRACE1    = 11;
   // timing in ns and derived cycles at the 20 MHz input clock
   localparam int          CLK_NS         = 50;
   localparam int          TURN_NS        = 50;
   localparam int          TURN_CYC       = (TURN_NS + CLK_NS - 1) / CLK_NS;
   localparam int          SAMPLE_NS      = 50;
   localparam int          SAMPLE_CYC     = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;

   typedef enum logic [4:0] {
      ST_COLD    = 5'h01,
      ST_TURN    = 5'h02,
      ST_RESTORE = 5'h04,
      ST_RELEASE = 5'h08,
      ST_RUN     = 5'h10
   } seq_state_t;

   typedef struct packed {
      logic       trace_en;
      logic       hold_clk;
      logic [7:0] pipe_mhz;
   } boot_cfg_t;

   typedef struct packed {
      logic [2:0] status;
      logic       clk;
   } trace_pins_t;
endpackage

// ### src/cold_reset_boot_config_sequencer.sv
// module: cold reset sequence, boot vector capture, trace pin takeover
`timescale 1ns/100ps
// Operation
// - cold reset asserts reset, floats bus
// - stop sampling on negation, keep vector
// - then drive bus, buffer enable/direction high
// - hold-clock option may freeze system clock
// - then negate system reset pin
// - afterwards monitor reset pin as warm reset
// - reset pin input synchronised, asynchronous
// - pipeline clock 100..133 MHz from vector
// - trace mode takes over trace pins
// - trace status 1 defaults to gpio 11
// - test data output floats when idle
// - trace mode: interrupt in, pc out
// - turnaround cycles between bus owners
module cold_reset_boot_config_sequencer
   import boot_seq_pkg::*;
(
   input  wire logic             SYS_CLK_I,
   input  wire logic             SYS_RST_I,
   input  wire logic             COLD_RESET_IN_N_I,
   input  wire logic             SYSTEM_RESET_IO_N_I,
   output logic                  SYSTEM_RESET_IO_N_O,
   output logic                  SYSTEM_RESET_IO_OE_O,
   input  wire logic [BUS_W-1:0] MEMORY_DATA_BUS_I,
   input  wire logic [BUS_W-1:0] CORE_DATA_I,
   input  wire logic             CORE_DATA_EN_I,
   output logic [BUS_W-1:0]      MEMORY_DATA_BUS_O,
   output logic                  MEMORY_DATA_BUS_OE_O,
   output logic                  BOOT_BUFFER_OE_N_O,
   output logic                  BUFFER_DIRECTION_N_O,
   input  wire logic             CLK_DIV_TICK_I,
   output logic                  SYSTEM_CLOCK_OUT_O,
   output logic [7:0]            PIPE_CLK_MHZ_O,
   output logic                  DEBUG_TRACE_MODE_O,
   output logic                  WARM_RESET_O,
   output logic                  CORE_RESET_O,
   input  wire logic [3:0]       GPIO_PIN_I,
   input  wire logic [3:0]       GPIO_PIN_OE_I,
   input  wire logic [3:0]       TRACE_PINS_I,
   output logic [3:0]            GPIO_PIN_O,
   output logic [3:0]            GPIO_PIN_OE_O,
   input  wire logic             SCAN_SHIFT_I,
   input  wire logic             SCAN_TDO_I,
   input  wire logic             TRACE_PC_I,
   output logic                  TEST_DATA_OUT_O,
   output logic                  TEST_DATA_OUT_OE_O,
   input  wire logic             TEST_DATA_IN_I,
   output logic                  DEBUG_INTERRUPT_IN_O
);
   seq_state_t        state_r;
   boot_cfg_t         cfg_r;
   boot_cfg_t         cfg_nxt;
   trace_pins_t       trace_in;
   logic [1:0]        cold_sync_r;
   logic [1:0]        rst_sync_r;
   logic [1:0]        tdi_sync_r;
   logic [CFG_W-1:0]  vec_r;
   logic [3:0]        turn_cnt_r;
   logic              clk_r;
   logic              cold_act;
   logic              pin_low;
   logic              warm_arm_r;
   logic [CFG_PLL_W-1:0] pll_code;

   assign cold_act = ~cold_sync_r[1];
   assign pin_low  = ~rst_sync_r[1];
   assign trace_in = TRACE_PINS_I;

   // two-stage synchronisers for pins
   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         cold_sync_r <= 2'h0;
         rst_sync_r  <= 2'h3;
         tdi_sync_r  <= 2'h3;
      end else begin
         cold_sync_r <= {cold_sync_r[0], COLD_RESET_IN_N_I};
         rst_sync_r  <= {rst_sync_r[0], SYSTEM_RESET_IO_N_I};
         tdi_sync_r  <= {tdi_sync_r[0], TEST_DATA_IN_I};
      end
   end

   // sequence state
   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         state_r    <= ST_COLD;
         turn_cnt_r <= 4'h0;
      end else if (cold_act) begin
         state_r    <= ST_COLD;
         turn_cnt_r <= 4'h0;
      end else begin
         case (state_r)
            ST_COLD: begin
               state_r    <= ST_TURN;
               turn_cnt_r <= 4'(TURN_CYC);
            end
            ST_TURN: begin
               if (turn_cnt_r <= 4'h1) begin
                  state_r <= ST_RESTORE;
               end else begin
                  turn_cnt_r <= turn_cnt_r - 4'h1;
               end
            end
            ST_RESTORE: state_r <= ST_RELEASE;
            ST_RELEASE: state_r <= ST_RUN;
            ST_RUN:     state_r <= ST_RUN;
            default:    state_r <= ST_COLD;
         endcase
      end
   end

   // warm reset watch armed once the pin reads high after release
   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         warm_arm_r <= 1'b0;
      end else if (state_r != ST_RUN) begin
         warm_arm_r <= 1'b0;
      end else if (!pin_low) begin
         warm_arm_r <= 1'b1;
      end
   end

   // boot vector capture, only while cold reset is held
   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         vec_r <= CFG_RST;
      end else if (cold_act) begin
         vec_r <= MEMORY_DATA_BUS_I[CFG_W-1:0];
      end
   end

   assign pll_code = vec_r[CFG_PLL_LSB +: CFG_PLL_W];

   always_comb begin
      cfg_nxt          = cfg_r;
      cfg_nxt.trace_en = vec_r[CFG_TRACE_BIT];
      cfg_nxt.hold_clk = vec_r[CFG_HOLD_BIT];
      // clamp code to the legal pipeline range
      if (8'(PIPE_MHZ_MIN + 8'(pll_code) * 8'h5) > PIPE_MHZ_MAX) begin
         cfg_nxt.pipe_mhz = PIPE_MHZ_MAX;
      end else begin
         cfg_nxt.pipe_mhz = 8'(PIPE_MHZ_MIN + 8'(pll_code) * 8'h5);
      end
   end

   // latched at end of sampling, kept through warm resets
   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         cfg_r <= '{trace_en: 1'b0, hold_clk: 1'b0, pipe_mhz: PIPE_MHZ_MIN};
      end else if (state_r == ST_COLD && !cold_act) begin
         cfg_r <= cfg_nxt;
      end
   end

   // system clock out, frozen when hold option chosen
   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         clk_r <= 1'b0;
      end else if (cfg_r.hold_clk && state_r != ST_COLD && state_r != ST_TURN) begin
         clk_r <= clk_r;
      end else if (CLK_DIV_TICK_I) begin
         clk_r <= ~clk_r;
      end
   end

   // pin drivers from state
   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         SYSTEM_RESET_IO_OE_O  <= 1'b1;
         MEMORY_DATA_BUS_OE_O  <= 1'b0;
         BOOT_BUFFER_OE_N_O    <= 1'b0;
         BUFFER_DIRECTION_N_O  <= 1'b0;
         MEMORY_DATA_BUS_O     <= '0;
      end else begin
         SYSTEM_RESET_IO_OE_O  <= (state_r != ST_RELEASE && state_r != ST_RUN) || cold_act;
         MEMORY_DATA_BUS_OE_O  <= !cold_act && (state_r == ST_RESTORE || state_r == ST_RELEASE
                                  || state_r == ST_RUN) && CORE_DATA_EN_I;
         BOOT_BUFFER_OE_N_O    <= !cold_act && state_r != ST_COLD && state_r != ST_TURN;
         BUFFER_DIRECTION_N_O  <= !cold_act && state_r != ST_COLD && state_r != ST_TURN;
         MEMORY_DATA_BUS_O     <= CORE_DATA_I;
      end
   end

   assign SYSTEM_RESET_IO_N_O = 1'b0;
   assign SYSTEM_CLOCK_OUT_O  = clk_r;
   assign PIPE_CLK_MHZ_O      = cfg_r.pipe_mhz;
   assign DEBUG_TRACE_MODE_O  = cfg_r.trace_en;
   assign WARM_RESET_O        = state_r == ST_RUN && warm_arm_r && pin_low;
   assign CORE_RESET_O        = state_r != ST_RUN || (warm_arm_r && pin_low);

   // trace pins override gpio; bit 1 of status is gpio 11 otherwise
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_pin
         assign GPIO_PIN_O[g]    = cfg_r.trace_en ? trace_in[g] : GPIO_PIN_I[g];
         assign GPIO_PIN_OE_O[g] = cfg_r.trace_en ? 1'b1 : GPIO_PIN_OE_I[g];
      end
   endgenerate

   assign TEST_DATA_OUT_O      = cfg_r.trace_en ? TRACE_PC_I : SCAN_TDO_I;
   assign TEST_DATA_OUT_OE_O   = cfg_r.trace_en || SCAN_SHIFT_I;
   assign DEBUG_INTERRUPT_IN_O = cfg_r.trace_en && !tdi_sync_r[1];

   a_reset_drives: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      cold_act |=> SYSTEM_RESET_IO_OE_O && !MEMORY_DATA_BUS_OE_O && !BOOT_BUFFER_OE_N_O)
      else $error("cold reset did not take bus");
   a_restore_before: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      $fell(SYSTEM_RESET_IO_OE_O) |-> $past(BOOT_BUFFER_OE_N_O) && BUFFER_DIRECTION_N_O)
      else $error("reset released before buffers restored");
   a_cfg_kept: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      state_r == ST_RUN && $past(state_r) == ST_RUN |-> $stable(cfg_r))
      else $error("config changed outside cold reset");
   a_turn_gap: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      $rose(cold_sync_r[1]) |=> !MEMORY_DATA_BUS_OE_O [*2])
      else $error("bus driven without turnaround");
   a_pipe_range: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      PIPE_CLK_MHZ_O >= PIPE_MHZ_MIN && PIPE_CLK_MHZ_O <= PIPE_MHZ_MAX)
      else $error("pipeline clock out of range");
   a_hold_clk: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      cfg_r.hold_clk && state_r == ST_RUN && $past(state_r) == ST_RUN |-> $stable(clk_r))
      else $error("system clock not held");
   a_tdo_float: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      !SCAN_SHIFT_I && !cfg_r.trace_en |-> !TEST_DATA_OUT_OE_O)
      else $error("test data out driven when idle");
   a_warm_seen: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      state_r == ST_RUN && warm_arm_r && !SYSTEM_RESET_IO_N_I && !cold_act ##1 state_r == ST_RUN
      ##1 state_r == ST_RUN |-> WARM_RESET_O)
      else $error("warm reset not seen");
   a_trace_pins: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      !cfg_r.trace_en |-> GPIO_PIN_OE_O[1] == GPIO_PIN_OE_I[1])
      else $error("gpio default lost");

   a_bus_float: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      cold_act |=> !MEMORY_DATA_BUS_OE_O)
      else $error("bus driven during cold reset");

   a_dir_low: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      cold_act |=> !BUFFER_DIRECTION_N_O)
      else $error("buffer direction not low in cold reset");

   a_core_held: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      state_r != ST_RUN |-> CORE_RESET_O)
      else $error("core released before sequence end");

   a_vec_capture: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      cold_act |=> vec_r == $past(MEMORY_DATA_BUS_I[CFG_W-1:0]))
      else $error("boot vector not sampled");

   a_vec_hold: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      !cold_act |=> $stable(vec_r))
      else $error("boot vector sampled after negation");

   a_trace_latch: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      state_r == ST_COLD && !cold_act |=> cfg_r.trace_en == $past(vec_r[CFG_TRACE_BIT]))
      else $error("trace option not latched");

   a_hold_latch: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      state_r == ST_COLD && !cold_act |=> cfg_r.hold_clk == $past(vec_r[CFG_HOLD_BIT]))
      else $error("hold option not latched");

   a_buf_restore: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      state_r == ST_RELEASE |-> BOOT_BUFFER_OE_N_O && BUFFER_DIRECTION_N_O)
      else $error("buffers not restored before release");

   a_release_end: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      $fell(SYSTEM_RESET_IO_OE_O) |-> state_r == ST_RUN)
      else $error("reset released out of sequence");

   a_turn_idle: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      state_r == ST_TURN |-> !MEMORY_DATA_BUS_OE_O)
      else $error("bus driven in turnaround");

   a_bus_req: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      MEMORY_DATA_BUS_OE_O |-> $past(CORE_DATA_EN_I))
      else $error("bus driven without core request");

   a_warm_gate: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      WARM_RESET_O |-> !SYSTEM_RESET_IO_OE_O)
      else $error("own reset drive seen as warm reset");

   a_warm_core: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      WARM_RESET_O |-> CORE_RESET_O)
      else $error("warm reset does not hold core");

   a_trace_oe: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      cfg_r.trace_en |-> GPIO_PIN_OE_O == 4'hF)
      else $error("trace pins not driven");

   a_dint_off: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      !cfg_r.trace_en |-> !DEBUG_INTERRUPT_IN_O)
      else $error("debug interrupt outside trace mode");

   c_cold_seq: cover property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      state_r == ST_COLD ##[1:20] state_r == ST_RUN);
   c_warm:     cover property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I) WARM_RESET_O);
   c_trace:    cover property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      state_r == ST_RUN && cfg_r.trace_en);
   c_hold:     cover property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      state_r == ST_RUN && cfg_r.hold_clk);
endmodule

// ### tb/boot_board_model.sv
// board logic model: drives cold reset, boot vector and warm reset pulses
`timescale 1ns/100ps
module boot_board_model (
   input  wire logic        clk_i,
   input  wire logic        rst_oe_i,
   output logic             cold_n_o,
   output logic [31:0]      bus_o,
   output logic             rst_pin_n_o
);
   logic        drive_r = 1'b0;
   logic        warm_r  = 1'b0;
   logic [15:0] vec_r   = 16'h0000;
   logic [31:0] flt_r   = 32'h5A5A_F0F0;
   initial cold_n_o = 1'b1;
   // released lines show a pattern that changes every cycle
   always @(negedge clk_i) begin
      flt_r <= ~flt_r;
   end
   assign bus_o = {flt_r[31:16], drive_r ? vec_r : flt_r[15:0]};
   // reset pin has a pull-up; low while the device or the board drives it
   assign rst_pin_n_o = ~(rst_oe_i | warm_r);
   task automatic cold(input logic [15:0] v, input int len);
      cold_n_o = 1'b0;
      repeat (4) @(negedge clk_i);
      vec_r = v;
      drive_r = 1'b1;
      repeat (len) @(negedge clk_i);
      cold_n_o = 1'b1;
      repeat (3) @(negedge clk_i);
      drive_r = 1'b0;
   endtask
   task automatic warm(input int len);
      warm_r = 1'b1;
      repeat (len) @(negedge clk_i);
      warm_r = 1'b0;
   endtask
endmodule

// ### tb/cold_reset_boot_config_sequencer_test.sv
// testbench: cold reset sequence, boot vector capture, pin takeover
`timescale 1ns/100ps
module cold_reset_boot_config_sequencer_test;
   import boot_seq_pkg::*;
   logic             clk = 1'b0;
   logic             rst = 1'b1;
   logic             cold_n, pin_n, rst_oe, rst_o, bus_oe, boe_n, bdir_n, sclk;
   logic             core_en = 1'b0, tick = 1'b0, shift = 1'b0, tdo = 1'b0;
   logic             tpc = 1'b0, tdi = 1'b1, trace, warm, core_rst, td_o, td_oe, dint;
   logic [BUS_W-1:0] board_bus, bus_out, bus_in, core_data = '0;
   logic [3:0]       gp = 4'h0, gp_oe = 4'h0, tr = 4'h0, gp_o, gp_oe_o;
   logic [7:0]       mhz;
   int               errors = 0;
   int               checks_done = 0;
   always #25 clk = ~clk;
   always @(negedge clk) tick <= ~tick;
   assign bus_in = bus_oe ? bus_out : board_bus;
   boot_board_model board (.clk_i(clk), .rst_oe_i(rst_oe), .cold_n_o(cold_n),
      .bus_o(board_bus), .rst_pin_n_o(pin_n));
   cold_reset_boot_config_sequencer dut (.SYS_CLK_I(clk), .SYS_RST_I(rst),
      .COLD_RESET_IN_N_I(cold_n), .SYSTEM_RESET_IO_N_I(pin_n), .SYSTEM_RESET_IO_N_O(rst_o),
      .SYSTEM_RESET_IO_OE_O(rst_oe), .MEMORY_DATA_BUS_I(bus_in), .CORE_DATA_I(core_data),
      .CORE_DATA_EN_I(core_en), .MEMORY_DATA_BUS_O(bus_out), .MEMORY_DATA_BUS_OE_O(bus_oe),
      .BOOT_BUFFER_OE_N_O(boe_n), .BUFFER_DIRECTION_N_O(bdir_n), .CLK_DIV_TICK_I(tick),
      .SYSTEM_CLOCK_OUT_O(sclk), .PIPE_CLK_MHZ_O(mhz), .DEBUG_TRACE_MODE_O(trace),
      .WARM_RESET_O(warm), .CORE_RESET_O(core_rst), .GPIO_PIN_I(gp), .GPIO_PIN_OE_I(gp_oe),
      .TRACE_PINS_I(tr), .GPIO_PIN_O(gp_o), .GPIO_PIN_OE_O(gp_oe_o), .SCAN_SHIFT_I(shift),
      .SCAN_TDO_I(tdo), .TRACE_PC_I(tpc), .TEST_DATA_OUT_O(td_o),
      .TEST_DATA_OUT_OE_O(td_oe), .TEST_DATA_IN_I(tdi), .DEBUG_INTERRUPT_IN_O(dint));
   task automatic end_sim();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("Error %0t: %s", $time, msg);
      end
   endtask
   task automatic wait_lvl(ref logic s, input logic v, input string msg);
      int n;
      for (n = 0; n < 40 && s !== v; n++) @(negedge clk);
      if (s !== v) begin
         errors++;
         $display("Error %0t: timeout on %s", $time, msg);
         end_sim();
      end
   endtask
   task automatic t_cold(input logic [2:0] code, input logic trc, input logic hld);
      logic [15:0] vec;
      logic [7:0]  exp_mhz;
      logic        s;
      int          n;
      vec = {11'h000, hld, trc, code};
      exp_mhz = (code == 3'h7) ? 8'h85 : 8'h64 + 8'(code) * 8'h05;
      core_en = 1'b1;
      core_data = 32'hA5C3_0F96 ^ 32'(code);
      fork
         board.cold(vec, 6);
         begin
            repeat (6) @(negedge clk);
            chk({rst_oe, bus_oe, boe_n, bdir_n}, 32'h8, "cold reset outputs");
         end
      join
      wait_lvl(rst_oe, 1'b0, "reset release");
      chk({boe_n, bdir_n}, 32'h3, "buffer controls");
      repeat (2) @(negedge clk);
      chk(bus_oe, 1'b1, "bus enable");
      chk(bus_out, core_data, "bus data");
      chk({rst_o, core_rst, warm}, 32'h0, "core released");
      s = sclk;
      n = 0;
      repeat (4) begin
         @(negedge clk);
         if (sclk !== s) n++;
         s = sclk;
      end
      chk(n == 0, hld, "system clock hold");
      chk(mhz, exp_mhz, "pipeline clock");
      chk(trace, trc, "trace mode");
      gp = 4'hA;
      gp_oe = 4'h5;
      tr = 4'hF;
      #1;
      chk({gp_o, gp_oe_o}, trc ? 32'hFF : 32'hA5, "pin mux");
      $display("test cold code %0d done", code);
   endtask
   task automatic t_test(input logic trc);
      shift = 1'b0;
      tdi = 1'b0;
      repeat (3) @(negedge clk);
      if (!trc) chk(td_oe, 1'b0, "tdo not floated");
      chk(dint, trc, "debug interrupt");
      shift = 1'b1;
      tdo = 1'b1;
      #1;
      chk({td_oe, td_o}, trc ? 32'h2 : 32'h3, "tdo shift");
      shift = 1'b0;
      tdi = 1'b1;
      $display("test scan done");
   endtask
   task automatic t_warm();
      logic [7:0] m;
      m = mhz;
      fork
         board.warm(6);
         begin
            repeat (5) @(negedge clk);
            chk(warm, 1'b1, "warm reset seen");
         end
      join
      repeat (4) @(negedge clk);
      chk(warm, 1'b0, "warm reset ended");
      chk(mhz, m, "config kept");
      $display("test warm done");
   endtask
   initial begin
      repeat (5) @(negedge clk);
      rst = 1'b0;
      for (int i = 0; i < 8; i++) begin
         t_cold(3'(i), i[0], i[1]);
         t_test(i[0]);
      end
      t_warm();
      end_sim();
   end
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      $display("Error %0t: run timed out", $time);
      end_sim();
   end
endmodule
